// File: perf_monitor_reg_defines.vh
// Register map, field positions and reset values of the monitoring register bank
`ifndef PERF_MONITOR_REG_DEFINES_VH
`define PERF_MONITOR_REG_DEFINES_VH
`define OFS_STATUS      12'h0800
`define OFS_QCTL0       12'h0808
`define OFS_QCTL2       12'h0810
`define OFS_QCTL3       12'h0818
`define OFS_IOB_SUB     12'h0828
`define OFS_BZ_SUB      12'h0830
`define OFS_CTL_BASE    12'h0840
`define OFS_MASTER      12'h0880
`define OFS_ARB0        12'h0890
`define OFS_ARB1        12'h0898
`define OFS_IMT_SUB     12'h08A0
`define OFS_IRQ_MASK    12'h08B0
`define OFS_CNT_BASE    12'h08C0
`define OFS_DC_BASE     12'h0980
`define OFS_DC_LAST     12'h09C8
`define OFS_CTL1        12'h0848
`define OFS_CTL2        12'h0850
`define OFS_CTL3        12'h0858
`define OFS_CTL4        12'h0860
`define OFS_CTL5        12'h0868
`define OFS_CTL6        12'h0870
`define OFS_CTL7        12'h0878
`define OFS_CNT1        12'h08C8
`define OFS_CNT2        12'h08D0
`define OFS_CNT3        12'h08D8
`define OFS_CNT4        12'h08E0
`define OFS_CNT5        12'h08E8
`define OFS_CNT6        12'h08F0
`define OFS_CNT7        12'h08F8
`define OFS_DC1         12'h0988
`define OFS_DC2         12'h0990
`define OFS_DC3         12'h0998
`define OFS_DC4         12'h09A0
`define OFS_DC5         12'h09A8
`define OFS_DC6         12'h09B0
`define OFS_DC7         12'h09B8
`define OFS_DC8         12'h09C0
`define REG_STEP        8
`define CTL_EN          0
`define NUM_SUB         6
`define BIT_EN          0
`define BIT_GLB         1
`define BIT_CLR         2
`define BIT_CKEN        3
`define MASTER_W        4
`define CNT_W           48
`define NUM_CNT         8
`define NUM_DC          10
`define ZERO64          64'h0000_0000_0000_0000
`define ZERO48          48'h0000_0000_0000
`define CNT_ONE         48'h0000_0000_0001
`define CNT_ALL1        48'hFFFF_FFFF_FFFF
`define ZERO8           8'h00
`define ZERO4           4'h0
`endif

// File: home_agent_perf_monitor_csrs.v
// Monitoring register bank with eight event counters behind an Avalon-MM slave
//
// Chosen here: the Avalon-MM interface to the registers.
`include "perf_monitor_reg_defines.vh"
`default_nettype none
module home_agent_perf_monitor_csrs (
    input  wire        CORE_CLK_I,
    input  wire        SRST_I,
    input  wire [11:0] AVS_ADDRESS_I,
    input  wire        AVS_READ_I,
    input  wire        AVS_WRITE_I,
    input  wire [63:0] AVS_WRITEDATA_I,
    input  wire [7:0]  AVS_BYTEENABLE_I,
    output wire [63:0] AVS_READDATA_O,
    output wire        AVS_WAITREQUEST_O,
    input  wire [7:0]  EVENT_I,
    input  wire        GLOBAL_EN_I,
    output wire        IRQ_O
);
    reg  [`MASTER_W-1:0]  master_ff;
    reg  [7:0]            ovf_ff;
    reg  [7:0]            irq_mask_ff;
    reg  [63:0]           ctl_ff [0:`NUM_CNT-1];
    reg  [`CNT_W-1:0]     cnt_ff [0:`NUM_CNT-1];
    reg  [63:0]           sub_ff [0:5];
    reg  [63:0]           dc_ff  [0:`NUM_DC-1];
    reg  [63:0]           rdata_ff;
    reg  [1:0]            bus_state_ff;
    reg  [1:0]            nxt_bus_state;
    wire                  answer_now;
    reg  [63:0]           nxt_rdata;
    wire [63:0]           be_mask;
    wire                  wr_go;
    wire                  rd_go;
    wire                  count_on;
    wire [7:0]            ovf_evt;
    wire                  clr_pulse;
    genvar                g;

    // Sub-register index: 0..2 queue ctl, 3 IOB, 4 BZ, 5 ARB0, 15 for any other offset
    function [3:0] sub_idx;
        input [11:0] a;
        begin
            case (a)
                `OFS_QCTL0:   sub_idx = 4'd0;
                `OFS_QCTL2:   sub_idx = 4'd1;
                `OFS_QCTL3:   sub_idx = 4'd2;
                `OFS_IOB_SUB: sub_idx = 4'd3;
                `OFS_BZ_SUB:  sub_idx = 4'd4;
                `OFS_ARB0:    sub_idx = 4'd5;
                default:      sub_idx = 4'd15;
            endcase
        end
    endfunction

    // Mask of written bytes
    generate
        for (g = 0; g < 8; g = g + 1) begin : gen_be
            assign be_mask[g*8 +: 8] = {8{AVS_BYTEENABLE_I[g]}};
        end
    endgenerate

    // Address match of one register
    function is_ofs;
        input [11:0] a;
        input [11:0] ofs;
        begin
            is_ofs = (a == ofs);
        end
    endfunction

    // Byte-lane merge of a write into a 64-bit register
    function [63:0] merge_be;
        input [63:0] old_val;
        input [63:0] new_val;
        input [63:0] mask;
        begin
            merge_be = (old_val & ~mask) | (new_val & mask);
        end
    endfunction

    // Bus handshake states
    localparam [1:0] BUS_IDLE   = 2'b01;
    localparam [1:0] BUS_ANSWER = 2'b10;

    // One wait cycle per access
    always @* begin
        case (bus_state_ff)
            BUS_IDLE: begin
                if (AVS_READ_I | AVS_WRITE_I)
                    nxt_bus_state = BUS_ANSWER;
                else
                    nxt_bus_state = BUS_IDLE;
            end
            BUS_ANSWER: nxt_bus_state = BUS_IDLE;
            default:    nxt_bus_state = BUS_IDLE;
        endcase
    end

    always @(posedge CORE_CLK_I) begin
        if (SRST_I)
            bus_state_ff <= BUS_IDLE;
        else
            bus_state_ff <= nxt_bus_state;
    end

    assign answer_now        = (bus_state_ff == BUS_ANSWER);
    assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~answer_now;
    // Write commits only at the edge where waitrequest is low
    assign wr_go             = AVS_WRITE_I & answer_now;
    // Read data fetched one cycle early, so it stands at the taking edge
    assign rd_go             = AVS_READ_I & ~answer_now;
    assign AVS_READDATA_O    = rdata_ff;
    assign clr_pulse         = wr_go & (AVS_ADDRESS_I == `OFS_MASTER)
                               & AVS_BYTEENABLE_I[0] & AVS_WRITEDATA_I[`BIT_CLR];
    assign count_on = master_ff[`BIT_CKEN] & master_ff[`BIT_EN];
    assign IRQ_O    = |(ovf_ff & irq_mask_ff);

    generate
        for (g = 0; g < `NUM_CNT; g = g + 1) begin : gen_cnt
            wire [31:0]       cnt_sum  = `OFS_CNT_BASE + g * `REG_STEP;
            wire [31:0]       ctl_sum  = `OFS_CTL_BASE + g * `REG_STEP;
            wire              wr_cnt   = wr_go & is_ofs(AVS_ADDRESS_I, cnt_sum[11:0]);
            wire              wr_ctl   = wr_go & is_ofs(AVS_ADDRESS_I, ctl_sum[11:0]);
            wire              hit      = count_on & EVENT_I[g] & ctl_ff[g][`CTL_EN];
            wire [63:0]       cnt_wide = merge_be({16'h0, cnt_ff[g]}, AVS_WRITEDATA_I, be_mask);
            reg  [`CNT_W-1:0] nxt_cnt;
            reg  [63:0]       nxt_ctl;

            assign ovf_evt[g] = hit & (cnt_ff[g] == `CNT_ALL1);

            always @* begin
                nxt_cnt = cnt_ff[g];
                if (clr_pulse)
                    nxt_cnt = `ZERO48;
                else if (wr_cnt)
                    nxt_cnt = cnt_wide[`CNT_W-1:0];
                else if (hit)
                    nxt_cnt = cnt_ff[g] + `CNT_ONE;
            end

            // Control register n for counter n
            always @* begin
                nxt_ctl = ctl_ff[g];
                if (wr_ctl)
                    nxt_ctl = merge_be(ctl_ff[g], AVS_WRITEDATA_I, be_mask);
            end

            always @(posedge CORE_CLK_I) begin
                if (SRST_I) begin
                    cnt_ff[g] <= `ZERO48;
                    ctl_ff[g] <= `ZERO64;
                end else begin
                    cnt_ff[g] <= nxt_cnt;
                    ctl_ff[g] <= nxt_ctl;
                end
            end
        end
    endgenerate

    // Sub-control and sub-counter storage
    generate
        for (g = 0; g < `NUM_SUB; g = g + 1) begin : gen_sub
            wire       wr_sub = wr_go & (sub_idx(AVS_ADDRESS_I) == g);
            reg [63:0] nxt_sub;

            always @* begin
                nxt_sub = sub_ff[g];
                if (wr_sub)
                    nxt_sub = merge_be(sub_ff[g], AVS_WRITEDATA_I, be_mask);
            end

            always @(posedge CORE_CLK_I) begin
                if (SRST_I)
                    sub_ff[g] <= `ZERO64;
                else
                    sub_ff[g] <= nxt_sub;
            end
        end

        for (g = 0; g < `NUM_DC; g = g + 1) begin : gen_dc
            wire [31:0] dc_sum = `OFS_DC_BASE + g * `REG_STEP;
            wire        wr_dc  = wr_go & is_ofs(AVS_ADDRESS_I, dc_sum[11:0]);
            reg  [63:0] nxt_dc;

            always @* begin
                nxt_dc = dc_ff[g];
                if (wr_dc)
                    nxt_dc = merge_be(dc_ff[g], AVS_WRITEDATA_I, be_mask);
            end

            always @(posedge CORE_CLK_I) begin
                if (SRST_I)
                    dc_ff[g] <= `ZERO64;
                else
                    dc_ff[g] <= nxt_dc;
            end
        end
    endgenerate

    // Strobes of the singly placed registers
    wire                  wr_arb1;
    wire                  wr_imt;
    wire                  wr_master;
    wire                  wr_status;
    wire                  wr_irq_mask;
    assign wr_arb1     = wr_go & is_ofs(AVS_ADDRESS_I, `OFS_ARB1);
    assign wr_imt      = wr_go & is_ofs(AVS_ADDRESS_I, `OFS_IMT_SUB);
    assign wr_master   = wr_go & is_ofs(AVS_ADDRESS_I, `OFS_MASTER) & AVS_BYTEENABLE_I[0];
    assign wr_status   = wr_go & is_ofs(AVS_ADDRESS_I, `OFS_STATUS) & AVS_BYTEENABLE_I[0];
    assign wr_irq_mask = wr_go & is_ofs(AVS_ADDRESS_I, `OFS_IRQ_MASK) & AVS_BYTEENABLE_I[0];

    // Remaining arbiter and in-flight table sub-counters
    reg  [63:0]           arb1_ff;
    reg  [63:0]           imt_ff;
    reg  [63:0]           nxt_arb1;
    reg  [63:0]           nxt_imt;

    always @* begin
        nxt_arb1 = arb1_ff;
        nxt_imt  = imt_ff;
        if (wr_arb1)
            nxt_arb1 = merge_be(arb1_ff, AVS_WRITEDATA_I, be_mask);
        if (wr_imt)
            nxt_imt = merge_be(imt_ff, AVS_WRITEDATA_I, be_mask);
    end

    always @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            arb1_ff <= `ZERO64;
            imt_ff  <= `ZERO64;
        end else begin
            arb1_ff <= nxt_arb1;
            imt_ff  <= nxt_imt;
        end
    end

    // Master, status and interrupt mask
    reg  [`MASTER_W-1:0]  nxt_master;
    reg  [7:0]            nxt_ovf;
    reg  [7:0]            nxt_irq_mask;

    always @* begin
        nxt_master = master_ff;
        if (wr_master) begin
            nxt_master[`BIT_CKEN] = AVS_WRITEDATA_I[`BIT_CKEN];
            nxt_master[`BIT_GLB]  = AVS_WRITEDATA_I[`BIT_GLB];
            nxt_master[`BIT_CLR]  = 1'b0;
            if (!AVS_WRITEDATA_I[`BIT_GLB])
                nxt_master[`BIT_EN] = AVS_WRITEDATA_I[`BIT_EN];
        end
        if (master_ff[`BIT_GLB])
            nxt_master[`BIT_EN] = GLOBAL_EN_I;
        else if (|ovf_evt)
            nxt_master[`BIT_EN] = 1'b0;
    end

    // Overflow sets flag, set wins over clear
    always @* begin
        nxt_ovf = ovf_ff | ovf_evt;
        if (clr_pulse)
            nxt_ovf = ovf_evt;
        else if (wr_status)
            nxt_ovf = (ovf_ff & ~AVS_WRITEDATA_I[7:0]) | ovf_evt;
    end

    always @* begin
        nxt_irq_mask = irq_mask_ff;
        if (wr_irq_mask)
            nxt_irq_mask = AVS_WRITEDATA_I[7:0];
    end

    always @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            master_ff   <= `ZERO4;
            ovf_ff      <= `ZERO8;
            irq_mask_ff <= `ZERO8;
        end else begin
            master_ff   <= nxt_master;
            ovf_ff      <= nxt_ovf;
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    // Read decode, every mapped offset listed
    always @* begin
        nxt_rdata = `ZERO64;
        case (AVS_ADDRESS_I)
            `OFS_STATUS:   nxt_rdata = {56'h0, ovf_ff};
            `OFS_QCTL0:    nxt_rdata = sub_ff[0];
            `OFS_QCTL2:    nxt_rdata = sub_ff[1];
            `OFS_QCTL3:    nxt_rdata = sub_ff[2];
            `OFS_IOB_SUB:  nxt_rdata = sub_ff[3];
            `OFS_BZ_SUB:   nxt_rdata = sub_ff[4];
            `OFS_CTL_BASE: nxt_rdata = ctl_ff[0];
            `OFS_CTL1:     nxt_rdata = ctl_ff[1];
            `OFS_CTL2:     nxt_rdata = ctl_ff[2];
            `OFS_CTL3:     nxt_rdata = ctl_ff[3];
            `OFS_CTL4:     nxt_rdata = ctl_ff[4];
            `OFS_CTL5:     nxt_rdata = ctl_ff[5];
            `OFS_CTL6:     nxt_rdata = ctl_ff[6];
            `OFS_CTL7:     nxt_rdata = ctl_ff[7];
            `OFS_MASTER:   nxt_rdata = {60'h0, master_ff};
            `OFS_ARB0:     nxt_rdata = sub_ff[5];
            `OFS_ARB1:     nxt_rdata = arb1_ff;
            `OFS_IMT_SUB:  nxt_rdata = imt_ff;
            `OFS_IRQ_MASK: nxt_rdata = {56'h0, irq_mask_ff};
            `OFS_CNT_BASE: nxt_rdata = {16'h0, cnt_ff[0]};
            `OFS_CNT1:     nxt_rdata = {16'h0, cnt_ff[1]};
            `OFS_CNT2:     nxt_rdata = {16'h0, cnt_ff[2]};
            `OFS_CNT3:     nxt_rdata = {16'h0, cnt_ff[3]};
            `OFS_CNT4:     nxt_rdata = {16'h0, cnt_ff[4]};
            `OFS_CNT5:     nxt_rdata = {16'h0, cnt_ff[5]};
            `OFS_CNT6:     nxt_rdata = {16'h0, cnt_ff[6]};
            `OFS_CNT7:     nxt_rdata = {16'h0, cnt_ff[7]};
            `OFS_DC_BASE:  nxt_rdata = dc_ff[0];
            `OFS_DC1:      nxt_rdata = dc_ff[1];
            `OFS_DC2:      nxt_rdata = dc_ff[2];
            `OFS_DC3:      nxt_rdata = dc_ff[3];
            `OFS_DC4:      nxt_rdata = dc_ff[4];
            `OFS_DC5:      nxt_rdata = dc_ff[5];
            `OFS_DC6:      nxt_rdata = dc_ff[6];
            `OFS_DC7:      nxt_rdata = dc_ff[7];
            `OFS_DC8:      nxt_rdata = dc_ff[8];
            `OFS_DC_LAST:  nxt_rdata = dc_ff[9];
            // Unmapped offsets read zero
            default:       nxt_rdata = `ZERO64;
        endcase
    end

    always @(posedge CORE_CLK_I) begin
        if (SRST_I)
            rdata_ff <= `ZERO64;
        else if (rd_go)
            rdata_ff <= nxt_rdata;
    end

endmodule
`default_nettype wire

// File: perf_monitor_reg_csr_assertions.sv
// Port-level assertions for the monitoring register bank
`default_nettype none
module perf_monitor_reg_csr_checker (
    input wire logic        CORE_CLK_I,
    input wire logic        SRST_I,
    input wire logic [11:0] AVS_ADDRESS_I,
    input wire logic        AVS_READ_I,
    input wire logic        AVS_WRITE_I,
    input wire logic [63:0] AVS_READDATA_O,
    input wire logic        AVS_WAITREQUEST_O,
    input wire logic [7:0]  EVENT_I,
    input wire logic        IRQ_O
);
    wire logic req = AVS_READ_I || AVS_WRITE_I;
    wire logic rok = AVS_READ_I && !AVS_WAITREQUEST_O;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (SRST_I);
    a_wait_first: assert property (req && !$past(req) |-> AVS_WAITREQUEST_O)
        else $error("waitrequest low in first request cycle");
    a_wait_one: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("request not answered after one cycle");
    a_master_upper: assert property (rok && AVS_ADDRESS_I == 12'h0880 |->
        AVS_READDATA_O[63:4] == 60'h0) else $error("master upper bits not zero");
    a_status_upper: assert property (rok && AVS_ADDRESS_I == 12'h0800 |->
        AVS_READDATA_O[63:8] == 56'h0) else $error("status upper bits not zero");
    a_count_width: assert property (rok && AVS_ADDRESS_I[11:6] == 6'h23 |->
        AVS_READDATA_O[63:48] == 16'h0) else $error("counter wider than 48 bits");
    a_unmapped_zero: assert property (rok && AVS_ADDRESS_I[11:7] == 5'h12 |->
        AVS_READDATA_O == 64'h0) else $error("unmapped read not zero");
    a_irq_cause: assert property ($rose(IRQ_O) |-> $past(|EVENT_I) || $past(AVS_WRITE_I))
        else $error("interrupt rose without event or write");
    a_irq_drop: assert property ($fell(IRQ_O) |-> $past(AVS_WRITE_I))
        else $error("interrupt fell without a write");
    a_data_hold: assert property (!$past(AVS_READ_I) |-> $stable(AVS_READDATA_O))
        else $error("read data changed without a read");
    cover property (rok && AVS_ADDRESS_I == 12'h0880);
    cover property ($rose(IRQ_O));
    cover property (rok && AVS_ADDRESS_I == 12'h0900);
endmodule
bind home_agent_perf_monitor_csrs perf_monitor_reg_csr_checker u_chk (.CORE_CLK_I, .SRST_I, .AVS_ADDRESS_I,
    .AVS_READ_I, .AVS_WRITE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .EVENT_I, .IRQ_O);
`default_nettype wire

// File: test_home_agent_perf_monitor_csrs.sv
// Self-checking bench for the monitoring register bank
`default_nettype none
module test_home_agent_perf_monitor_csrs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        rd_req = 1'b0;
    logic        wr_req = 1'b0;
    logic        glb_en = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [63:0] wdata = 64'h0;
    logic [7:0]  evt = 8'h00;
    logic [63:0] rdata, rd_val;
    logic        waitreq, irq;
    int          err_count, checks;
    home_agent_perf_monitor_csrs u_dut (.CORE_CLK_I(clk), .SRST_I(srst), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd_req), .AVS_WRITE_I(wr_req), .AVS_WRITEDATA_I(wdata),
        .AVS_BYTEENABLE_I(8'hFF), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
        .EVENT_I(evt), .GLOBAL_EN_I(glb_en), .IRQ_O(irq));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [63:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wr_req <= w;
        rd_req <= !w;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (n >= 50) begin
            err_count++;
            give_verdict();
        end
        rd_val = rdata;
        wr_req <= 1'b0;
        rd_req <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [63:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [63:0] e);
        bus(1'b0, a, 64'h0);
        chk(rd_val, e);
    endtask
    task automatic ev(input logic [7:0] m, input int n);
        @(posedge clk);
        evt <= m;
        repeat (n) @(posedge clk);
        evt <= 8'h00;
    endtask
    task automatic t_map();
        rd(12'h0880, 64'h0);
        rd(12'h0800, 64'h0);
        wr(12'h0880, 64'hFFFF_FFFF_FFFF_FFFF);
        rd(12'h0880, 64'hA);
        wr(12'h0880, 64'h0);
        wr(12'h0808, 64'h2800);
        rd(12'h0808, 64'h2800);
        wr(12'h0878, 64'h1);
        rd(12'h0878, 64'h1);
        wr(12'h0900, 64'hFFFF);
        rd(12'h0900, 64'h0);
    endtask
    task automatic t_gate();
        wr(12'h0840, 64'h1);
        wr(12'h0880, 64'h1);
        ev(8'h01, 5);
        rd(12'h08C0, 64'h0);
        wr(12'h0880, 64'h9);
        ev(8'h01, 5);
        rd(12'h08C0, 64'h5);
        wr(12'h0880, 64'h8);
        ev(8'h01, 3);
        rd(12'h08C0, 64'h5);
        rd(12'h0880, 64'h8);
    endtask
    task automatic t_ovf();
        wr(12'h08D8, 64'hFFFF_FFFF_FFFF_FFFF);
        rd(12'h08D8, 64'h0000_FFFF_FFFF_FFFF);
        wr(12'h0858, 64'h1);
        wr(12'h08B0, 64'h8);
        wr(12'h0880, 64'h9);
        ev(8'h08, 1);
        @(negedge clk);
        chk({63'h0, irq}, 64'h1);
        rd(12'h0800, 64'h8);
        rd(12'h0880, 64'h8);
        rd(12'h08D8, 64'h0);
        wr(12'h0800, 64'h8);
        rd(12'h0800, 64'h0);
        chk({63'h0, irq}, 64'h0);
    endtask
    task automatic t_clr();
        wr(12'h08D8, 64'hFFFF_FFFF_FFFF_FFFF);
        wr(12'h0880, 64'h9);
        ev(8'h08, 1);
        rd(12'h0800, 64'h8);
        wr(12'h0880, 64'hC);
        rd(12'h08C0, 64'h0);
        rd(12'h0800, 64'h0);
        rd(12'h0880, 64'h8);
        chk({63'h0, irq}, 64'h0);
    endtask
    task automatic t_glb();
        glb_en <= 1'b1;
        wr(12'h0880, 64'hA);
        rd(12'h0880, 64'hB);
        ev(8'h81, 2);
        rd(12'h08F8, 64'h2);
        rd(12'h08C0, 64'h2);
    endtask
    task automatic give_verdict();
        $display("err_count=%0d checks=%0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        #(40 * 2000);
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_map();
        t_gate();
        t_ovf();
        t_clr();
        t_glb();
        give_verdict();
    end
endmodule
`default_nettype wire
